// >>> include/mad_pkg.sv
`default_nettype none
// ****************************************************************
// shared constants and types of the move / arithmetic datapath
// ****************************************************************
package mad_pkg;

    // data and address widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int WORD_W = 16;

    // single-bit access is limited to the low part of data memory
    localparam logic [ADDR_W-1:0] BIT_ADDR_MAX = 8'h3F;

    // stack pointer step for one flag/work register pair
    localparam logic [ADDR_W-1:0] STACK_STEP = 8'h02;
    localparam logic [ADDR_W-1:0] STACK_RESET = 8'h00;

    // flag byte layout as stored on the stack
    localparam int FLAG_ZERO_POS = 0;
    localparam int FLAG_CARRY_POS = 1;
    localparam int FLAG_HALF_POS = 2;
    localparam int FLAG_RANGE_POS = 3;

    // reset value and byte constants
    localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;

    // instruction cycle: two clocks; indirect moves take two of them
    localparam int CLKS_PER_T = 2;
    localparam int INDIRECT_T = 2;

    // operations carried out by the datapath
    typedef enum logic [4:0] {
        OP_NOP,
        OP_MOV_A_I,
        OP_MOV_M_A,
        OP_MOV_A_M,
        OP_MOV_A_IO,
        OP_MOV_IO_A,
        OP_TIMER_SNAP,
        OP_TIMER_PRESET,
        OP_IND_LOAD,
        OP_IND_STORE,
        OP_XCH,
        OP_PUSH_FLAGS,
        OP_POP_FLAGS,
        OP_ADD_A_I,
        OP_ADD_A_M,
        OP_ADD_M_A,
        OP_ADDC_A_M,
        OP_ADDC_M_A,
        OP_ADDC_A,
        OP_ADDC_M,
        OP_SUB_A_I,
        OP_SUB_A_M,
        OP_SUB_M_A,
        OP_SUBC_A_M,
        OP_SUBC_M_A,
        OP_SUBC_A,
        OP_SUBC_M,
        OP_INC_M,
        OP_DEC_M,
        OP_CLEAR_M
    } mad_op_e;

endpackage
`default_nettype wire

// >>> src/mad_addsub.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// eight-bit adder / subtractor with carry, half carry and range flags
// ****************************************************************
module mad_addsub
    import mad_pkg::*;
(
    // operands
    input  wire logic [DATA_W-1:0] opA,
    input  wire logic [DATA_W-1:0] opB,
    input  wire logic              carryIn,
    input  wire logic              subtract,
    // result
    output logic      [DATA_W-1:0] result,
    output logic                   carryOut,
    output logic                   halfOut,
    output logic                   rangeOut
);
    logic [DATA_W-1:0] bEff;
    logic              cEff;
    logic [DATA_W:0]   full;
    logic [4:0]        low;

    // subtraction adds the two's complement; carry reads as borrow then
    always_comb begin
        bEff     = subtract ? ~opB : opB;
        cEff     = subtract ? ~carryIn : carryIn;
        full     = {1'b0, opA} + {1'b0, bEff} + {{DATA_W{1'b0}}, cEff};
        low      = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cEff};
        result   = full[DATA_W-1:0];
        carryOut = full[DATA_W] ^ subtract;
        halfOut  = low[4] ^ subtract;
        // same operand signs but a different result sign: out of range
        rangeOut = (opA[7] == bEff[7]) && (result[7] != opA[7]);
    end
endmodule
`default_nettype wire

// >>> src/mad_stack_ptr.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// stack pointer: software load, step up on push, step down on pop
// ****************************************************************
module mad_stack_ptr
    import mad_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // control
    input  wire logic              load,
    input  wire logic [ADDR_W-1:0] loadValue,
    input  wire logic              stepUp,
    input  wire logic              stepDown,
    // state
    output logic      [ADDR_W-1:0] stackPtr,
    output logic      [ADDR_W-1:0] stackPtrDown
);
    typedef struct packed {
        logic [ADDR_W-1:0] ptr;
    } mad_sp_s;

    mad_sp_s cur;
    mad_sp_s next_cur;

    // a step from the datapath wins over a software load in the same cycle
    always_comb begin
        next_cur = cur;
        if (stepUp) begin
            next_cur.ptr = cur.ptr + STACK_STEP;
        end else if (stepDown) begin
            next_cur.ptr = cur.ptr - STACK_STEP;
        end else if (load) begin
            next_cur.ptr = loadValue;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cur.ptr <= STACK_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign stackPtr     = cur.ptr;
    assign stackPtrDown = cur.ptr - STACK_STEP;
endmodule
`default_nettype wire

// >>> src/mad_datapath.sv
// How it works
// - zero flag set when an updating operation leaves an all-zero result
// - carry flag holds unsigned carry of add or borrow of subtract
// - half-carry flag set on a carry out of the low nibble, or on a borrow into it for subtract
// - signed-range flag set when the signed 8-bit result overflows
// - single-bit memory access is only valid for addresses up to 0x3F
// - immediate load and store to memory leave every flag alone
// - memory or IO load into work register updates only zero flag
// - work register to IO writes the byte, flags untouched
// - timer snapshot writes the 16-bit count to a memory word
// - timer preset loads the 16-bit count from a memory word
// - indirect load reads byte at pointer address, two instruction cycles
// - indirect store writes work register at pointer, two instruction cycles
// - exchange swaps work register and memory byte, flags untouched
// - push stores flags and work register at stack pointer, then adds 2
// - pop subtracts 2 first, then restores flags and work register
// - add sums work register with immediate or memory, all flags updated
// - add-with-carry also adds the carry flag, all flags updated
// - subtract uses two's complement of the subtrahend, all flags updated
// - subtract-with-borrow also subtracts the carry flag
// - increment and decrement a memory byte in place, all flags updated
// - clear writes zero to the memory byte, flags untouched
`timescale 1ns/10ps
`default_nettype none
module mad_datapath
    import mad_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // operation request
    input  wire logic              opValid,
    input  wire mad_op_e           opCode,
    input  wire logic [DATA_W-1:0] opImm,
    input  wire logic [ADDR_W-1:0] opAddr,
    output logic                   opReady,
    output logic                   opDone,
    output logic                   bitAddrOk,
    // stack pointer load
    input  wire logic              stackLoad,
    input  wire logic [ADDR_W-1:0] stackLoadValue,
    output logic      [ADDR_W-1:0] stackPtr,
    // data memory, asynchronous read of the byte pair at memAddr
    output logic      [ADDR_W-1:0] memAddr,
    input  wire logic [DATA_W-1:0] memRdData,
    input  wire logic [DATA_W-1:0] memRdHi,
    output logic                   memWrEn,
    output logic                   memWrHiEn,
    output logic      [DATA_W-1:0] memWrData,
    output logic      [DATA_W-1:0] memWrHi,
    // io space, asynchronous read
    output logic      [ADDR_W-1:0] ioAddr,
    input  wire logic [DATA_W-1:0] ioRdData,
    output logic                   ioWrEn,
    output logic      [DATA_W-1:0] ioWrData,
    // sixteen-bit timer
    input  wire logic [WORD_W-1:0] timerCount,
    output logic                   timerLoad,
    output logic      [WORD_W-1:0] timerLoadValue,
    // architectural state
    output logic      [DATA_W-1:0] workRegister,
    output logic                   zeroFlag,
    output logic                   carryFlag,
    output logic                   halfCarryBit,
    output logic                   signedRangeBit
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXEC,
        ST_PTR,
        ST_SETTLE,
        ST_IND
    } mad_state_e;

    typedef struct packed {
        mad_state_e        st;
        mad_op_e           op;
        logic [DATA_W-1:0] imm;
        logic [DATA_W-1:0] work;
        logic              z;
        logic              c;
        logic              hc;
        logic              ov;
        logic [ADDR_W-1:0] mAddr;
        logic              mWr;
        logic              mWrHi;
        logic [DATA_W-1:0] mData;
        logic [DATA_W-1:0] mHi;
        logic [ADDR_W-1:0] iAddr;
        logic              iWr;
        logic [DATA_W-1:0] iData;
        logic              tLoad;
        logic [WORD_W-1:0] tValue;
        logic              done;
        logic              bitOk;
    } mad_dp_s;

    mad_dp_s cur;
    mad_dp_s next_cur;

    // ****************************************************************
    // arithmetic unit and stack pointer
    // ****************************************************************
    logic [DATA_W-1:0] aluA;
    logic [DATA_W-1:0] aluB;
    logic              aluCin;
    logic              aluSub;
    logic [DATA_W-1:0] aluRes;
    logic              aluC;
    logic              aluHc;
    logic              aluOv;
    logic              toMem;
    logic              isArith;
    logic              spUp;
    logic              spDown;
    logic [ADDR_W-1:0] spDownValue;

    mad_addsub u_addsub (
        .opA      (aluA),
        .opB      (aluB),
        .carryIn  (aluCin),
        .subtract (aluSub),
        .result   (aluRes),
        .carryOut (aluC),
        .halfOut  (aluHc),
        .rangeOut (aluOv)
    );

    mad_stack_ptr u_stack (
        .clk          (clk),
        .rst          (rst),
        .load         (stackLoad),
        .loadValue    (stackLoadValue),
        .stepUp       (spUp),
        .stepDown     (spDown),
        .stackPtr     (stackPtr),
        .stackPtrDown (spDownValue)
    );

    // operand selection; carry doubles as borrow for the subtract forms
    always_comb begin
        aluA    = cur.work;
        aluB    = memRdData;
        aluCin  = 1'b0;
        aluSub  = 1'b0;
        toMem   = 1'b0;
        isArith = 1'b1;
        unique case (cur.op)
            OP_ADD_A_I:  aluB = cur.imm;
            OP_ADD_A_M:  aluB = memRdData;
            OP_ADD_M_A:  toMem = 1'b1;
            OP_ADDC_A_M: aluCin = cur.c;
            OP_ADDC_M_A: begin
                aluCin = cur.c;
                toMem  = 1'b1;
            end
            OP_ADDC_A: begin
                aluB   = ZERO_BYTE;
                aluCin = cur.c;
            end
            OP_ADDC_M: begin
                aluA   = memRdData;
                aluB   = ZERO_BYTE;
                aluCin = cur.c;
                toMem  = 1'b1;
            end
            OP_SUB_A_I: begin
                aluB   = cur.imm;
                aluSub = 1'b1;
            end
            OP_SUB_A_M:  aluSub = 1'b1;
            OP_SUB_M_A: begin
                aluA   = memRdData;
                aluB   = cur.work;
                aluSub = 1'b1;
                toMem  = 1'b1;
            end
            OP_SUBC_A_M: begin
                aluSub = 1'b1;
                aluCin = cur.c;
            end
            OP_SUBC_M_A: begin
                aluA   = memRdData;
                aluB   = cur.work;
                aluSub = 1'b1;
                aluCin = cur.c;
                toMem  = 1'b1;
            end
            OP_SUBC_A: begin
                aluB   = ZERO_BYTE;
                aluSub = 1'b1;
                aluCin = cur.c;
            end
            OP_SUBC_M: begin
                aluA   = memRdData;
                aluB   = ZERO_BYTE;
                aluSub = 1'b1;
                aluCin = cur.c;
                toMem  = 1'b1;
            end
            OP_INC_M: begin
                aluA  = memRdData;
                aluB  = ONE_BYTE;
                toMem = 1'b1;
            end
            OP_DEC_M: begin
                aluA   = memRdData;
                aluB   = ONE_BYTE;
                aluSub = 1'b1;
                toMem  = 1'b1;
            end
            default: isArith = 1'b0;
        endcase
    end

    // stack steps: push in its execute cycle, before its write lands; pop before its read
    assign spUp   = (cur.st == ST_EXEC) && (cur.op == OP_PUSH_FLAGS);
    assign spDown = opValid && opReady && (opCode == OP_POP_FLAGS);

    // ****************************************************************
    // sequencing
    // ****************************************************************
    // a request is taken in idle and addresses the memory at once; the
    // next cycle reads, computes and posts writes that land one cycle later
    always_comb begin
        next_cur       = cur;
        next_cur.mWr   = 1'b0;
        next_cur.mWrHi = 1'b0;
        next_cur.iWr   = 1'b0;
        next_cur.tLoad = 1'b0;
        next_cur.done  = 1'b0;
        unique case (cur.st)
            ST_IDLE: begin
                if (opValid) begin
                    next_cur.op    = opCode;
                    next_cur.imm   = opImm;
                    next_cur.mAddr = opAddr;
                    next_cur.iAddr = opAddr;
                    // the bit unit outside may only touch the low memory page
                    next_cur.bitOk = (opAddr <= BIT_ADDR_MAX);
                    if (opCode == OP_PUSH_FLAGS) begin
                        next_cur.mAddr = stackPtr;
                    end else if (opCode == OP_POP_FLAGS) begin
                        next_cur.mAddr = spDownValue;
                    end
                    if (opCode == OP_IND_LOAD || opCode == OP_IND_STORE) begin
                        next_cur.st = ST_PTR;
                    end else begin
                        next_cur.st = ST_EXEC;
                    end
                end
            end
            ST_EXEC: begin
                next_cur.st   = ST_IDLE;
                next_cur.done = 1'b1;
                if (isArith) begin
                    next_cur.z  = (aluRes == ZERO_BYTE);
                    next_cur.c  = aluC;
                    next_cur.hc = aluHc;
                    next_cur.ov = aluOv;
                    if (toMem) begin
                        next_cur.mWr   = 1'b1;
                        next_cur.mData = aluRes;
                    end else begin
                        next_cur.work = aluRes;
                    end
                end
                unique case (cur.op)
                    OP_MOV_A_I: next_cur.work = cur.imm;
                    OP_MOV_M_A, OP_CLEAR_M: begin
                        next_cur.mWr   = 1'b1;
                        next_cur.mData = (cur.op == OP_CLEAR_M) ? ZERO_BYTE
                                                                : cur.work;
                    end
                    OP_MOV_A_M: begin
                        next_cur.work = memRdData;
                        next_cur.z    = (memRdData == ZERO_BYTE);
                    end
                    OP_MOV_A_IO: begin
                        next_cur.work = ioRdData;
                        next_cur.z    = (ioRdData == ZERO_BYTE);
                    end
                    OP_MOV_IO_A: begin
                        next_cur.iWr   = 1'b1;
                        next_cur.iData = cur.work;
                    end
                    OP_TIMER_SNAP: begin
                        next_cur.mWr   = 1'b1;
                        next_cur.mWrHi = 1'b1;
                        next_cur.mData = timerCount[DATA_W-1:0];
                        next_cur.mHi   = timerCount[WORD_W-1:DATA_W];
                    end
                    OP_TIMER_PRESET: begin
                        next_cur.tLoad  = 1'b1;
                        next_cur.tValue = {memRdHi, memRdData};
                    end
                    OP_XCH: begin
                        next_cur.work  = memRdData;
                        next_cur.mWr   = 1'b1;
                        next_cur.mData = cur.work;
                    end
                    OP_PUSH_FLAGS: begin
                        // work register in the low byte, flags above it
                        next_cur.mWr   = 1'b1;
                        next_cur.mWrHi = 1'b1;
                        next_cur.mData = cur.work;
                        next_cur.mHi   = ZERO_BYTE;
                        next_cur.mHi[FLAG_ZERO_POS]  = cur.z;
                        next_cur.mHi[FLAG_CARRY_POS] = cur.c;
                        next_cur.mHi[FLAG_HALF_POS]  = cur.hc;
                        next_cur.mHi[FLAG_RANGE_POS] = cur.ov;
                    end
                    OP_POP_FLAGS: begin
                        next_cur.work = memRdData;
                        next_cur.z    = memRdHi[FLAG_ZERO_POS];
                        next_cur.c    = memRdHi[FLAG_CARRY_POS];
                        next_cur.hc   = memRdHi[FLAG_HALF_POS];
                        next_cur.ov   = memRdHi[FLAG_RANGE_POS];
                    end
                    default: ;
                endcase
            end
            ST_PTR: begin
                // only the pointer's low byte addresses the small memory
                next_cur.mAddr = memRdData;
                next_cur.st    = ST_SETTLE;
            end
            ST_SETTLE: begin
                // spare clock fills out the second instruction cycle
                next_cur.st = ST_IND;
            end
            ST_IND: begin
                next_cur.st   = ST_IDLE;
                next_cur.done = 1'b1;
                if (cur.op == OP_IND_LOAD) begin
                    next_cur.work = memRdData;
                end else begin
                    next_cur.mWr   = 1'b1;
                    next_cur.mData = cur.work;
                end
            end
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            cur      <= '0;
            cur.st   <= ST_IDLE;
            cur.op   <= OP_NOP;
            cur.work <= WORK_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ports
    assign opReady        = (cur.st == ST_IDLE);
    assign opDone         = cur.done;
    assign bitAddrOk      = cur.bitOk;
    assign memAddr        = cur.mAddr;
    assign memWrEn        = cur.mWr;
    assign memWrHiEn      = cur.mWrHi;
    assign memWrData      = cur.mData;
    assign memWrHi        = cur.mHi;
    assign ioAddr         = cur.iAddr;
    assign ioWrEn         = cur.iWr;
    assign ioWrData       = cur.iData;
    assign timerLoad      = cur.tLoad;
    assign timerLoadValue = cur.tValue;
    assign workRegister   = cur.work;
    assign zeroFlag       = cur.z;
    assign carryFlag      = cur.c;
    assign halfCarryBit   = cur.hc;
    assign signedRangeBit = cur.ov;
endmodule
`default_nettype wire

// >>> verif/mad_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// port checks of the datapath
// ********************
module mad_checker
    import mad_pkg::*;
(
    // clock, reset and request
    input wire logic        clk, rst, opValid, opReady, opDone, bitAddrOk,
    input wire mad_op_e     opCode,
    input wire logic [7:0]  opAddr, workRegister, memWrData, ioWrData,
    // strobes and flags
    input wire logic        memWrEn, ioWrEn,
    input wire logic        zeroFlag, carryFlag, halfCarryBit, signedRangeBit
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    mad_op_e    curOp;
    wire logic [3:0] flags = {signedRangeBit, halfCarryBit, carryFlag, zeroFlag};
    wire logic  take = opValid && opReady;
    wire logic  indOp = opCode inside {OP_IND_LOAD, OP_IND_STORE};
    // operation in flight, held so the completion checks know what finished
    always_ff @(posedge clk) begin
        if (take) begin
            curOp <= opCode;
        end
    end
    chk_short_done: assert property (take && !indOp |-> ##2 opDone)
        else $error("short operation late");
    chk_ind_done: assert property (take && indOp |=> !opDone [*3] ##1 opDone)
        else $error("indirect move not two instruction cycles");
    chk_busy: assert property (take |=> !opReady)
        else $error("ready while busy");
    chk_flags_kept: assert property (opDone &&
        curOp inside {OP_MOV_A_I, OP_MOV_M_A, OP_MOV_IO_A, OP_XCH, OP_CLEAR_M, OP_PUSH_FLAGS,
        OP_IND_LOAD, OP_IND_STORE, OP_TIMER_SNAP, OP_TIMER_PRESET} |-> $stable(flags))
        else $error("flags changed by a move");
    chk_move_zero: assert property (opDone && curOp inside {OP_MOV_A_M, OP_MOV_A_IO}
        |-> zeroFlag == (workRegister == 8'h00) && $stable(flags[3:1]))
        else $error("move flag update wrong");
    chk_clear_zero: assert property (opDone && curOp == OP_CLEAR_M |->
        memWrEn && memWrData == 8'h00)
        else $error("clear did not write zero");
    chk_io_write: assert property (opDone && curOp == OP_MOV_IO_A |->
        ioWrEn && ioWrData == workRegister)
        else $error("io write wrong");
    chk_bit_range: assert property (take |=> bitAddrOk == ($past(opAddr) <= BIT_ADDR_MAX))
        else $error("bit range report wrong");
    cover property (take && indOp);
    cover property (opDone && curOp == OP_POP_FLAGS);
    cover property (opDone && halfCarryBit && carryFlag);
endmodule
bind mad_datapath mad_checker i_mad_checker (.*);
`default_nettype wire

// >>> verif/mad_env.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// data memory, io space and timer
// ********************
module mad_env
    import mad_pkg::*;
(
    // clock
    input wire logic        clk,
    // data memory, io space and timer
    input wire logic [7:0]  memAddr, memWrData, memWrHi, ioAddr, ioWrData,
    input wire logic        memWrEn, memWrHiEn, ioWrEn, timerLoad,
    input wire logic [15:0] timerLoadValue,
    output logic     [7:0]  memRdData, memRdHi, ioRdData,
    output logic     [15:0] timerCount
);
    logic [7:0] mem [256];
    logic [7:0] io [256];
    // reads are combinational because the datapath samples them in the same cycle
    assign memRdData = mem[memAddr];
    assign memRdHi = mem[memAddr + 8'h01];
    assign ioRdData = io[ioAddr];
    // writes land on the edge that ends the strobe cycle; timer holds between loads
    always @(posedge clk) begin
        if (memWrEn) mem[memAddr] <= memWrData;
        if (memWrHiEn) mem[memAddr + 8'h01] <= memWrHi;
        if (ioWrEn) io[ioAddr] <= ioWrData;
        if (timerLoad) timerCount <= timerLoadValue;
    end
endmodule
`default_nettype wire

// >>> verif/tb_mcu_move_arith_datapath.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// operation sequences against a reference
// ********************
module tb_mcu_move_arith_datapath
    import mad_pkg::*;
;
    logic clk = 0, rst = 1, opValid = 0, stackLoad = 0;
    mad_op_e opCode = OP_NOP;
    logic [7:0] opImm = 8'h00, opAddr = 8'h00, stackLoadValue = 8'h00, ew = 8'h00, esp = 8'h00, wa;
    logic [3:0] ef = 4'h0;
    logic [15:0] et = 16'hA55A;
    logic [7:0] sm [256];
    logic [7:0] sio [256];
    int errors = 0, checkCount = 0;
    wire logic opReady, opDone, bitAddrOk, memWrEn, memWrHiEn, ioWrEn, timerLoad;
    wire logic zeroFlag, carryFlag, halfCarryBit, signedRangeBit;
    wire logic [7:0] stackPtr, memAddr, memRdData, memRdHi, memWrData, memWrHi, ioAddr;
    wire logic [7:0] ioRdData, ioWrData, workRegister;
    wire logic [15:0] timerCount, timerLoadValue;
    mad_datapath i_mad_datapath (.*);
    mad_env i_mad_env (.*);
    always #12.5 clk = ~clk;
    task automatic chk(input logic [39:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // reference step first, then one request and a bounded wait for completion
    task automatic go(input mad_op_e o, input logic [7:0] i, a);
        logic [8:0] s; logic [4:0] n; logic [7:0] x, y; logic ci, sb, tm, d;
        {wa, x, y, ci, tm} = {a, ew, sm[a], 2'b00};
        sb = o inside {[OP_SUB_A_I:OP_SUBC_M], OP_DEC_M};
        if (o inside {[OP_ADDC_A_M:OP_ADDC_M], [OP_SUBC_A_M:OP_SUBC_M]}) ci = ef[1];
        case (o)
            OP_MOV_A_I: ew = i;
            OP_MOV_M_A: sm[a] = ew;
            OP_MOV_A_M: {ew, ef[0]} = {sm[a], sm[a] == 8'h00};
            OP_MOV_A_IO: {ew, ef[0]} = {sio[a], sio[a] == 8'h00};
            OP_MOV_IO_A: sio[a] = ew;
            OP_TIMER_SNAP: {sm[a + 8'h01], sm[a]} = et;
            OP_TIMER_PRESET: et = {sm[a + 8'h01], sm[a]};
            OP_IND_LOAD: ew = sm[sm[a]];
            OP_IND_STORE: {wa, sm[sm[a]]} = {sm[a], ew};
            OP_XCH: {ew, sm[a]} = {sm[a], ew};
            OP_PUSH_FLAGS: {wa, sm[esp + 8'h01], sm[esp]} = {esp, 4'h0, ef, ew};
            OP_POP_FLAGS: {wa, esp, ef, ew} = {esp - 8'h02, esp - 8'h02, sm[esp - 8'h01][3:0],
                                               sm[esp - 8'h02]};
            OP_CLEAR_M: sm[a] = 8'h00;
            OP_ADD_A_I, OP_SUB_A_I: y = i;
            OP_ADD_M_A, OP_ADDC_M_A: tm = 1'b1;
            OP_SUB_M_A, OP_SUBC_M_A: {x, y, tm} = {sm[a], ew, 1'b1};
            OP_ADDC_A, OP_SUBC_A: y = 8'h00;
            OP_ADDC_M, OP_SUBC_M: {x, y, tm} = {sm[a], 8'h00, 1'b1};
            OP_INC_M, OP_DEC_M: {x, y, tm} = {sm[a], 8'h01, 1'b1};
            default: ;
        endcase
        if (o == OP_PUSH_FLAGS) begin
            esp = esp + 8'h02;
        end
        if (o inside {[OP_ADD_A_I:OP_DEC_M]}) begin
            y = sb ? ~y : y;
            s = x + y + (sb ^ ci);
            n = x[3:0] + y[3:0] + (sb ^ ci);
            ef = {(x[7] == y[7]) && (s[7] != x[7]), n[4] ^ sb, s[8] ^ sb, s[7:0] == 8'h00};
            if (tm) sm[a] = s[7:0]; else ew = s[7:0];
        end
        @(posedge clk);
        {opValid, opImm, opAddr} <= {1'b1, i, a};
        opCode <= o;
        @(posedge clk);
        opValid <= 1'b0;
        for (int k = 0; k < 8 && d !== 1'b1; k++) begin
            @(posedge clk);
            #1 d = opDone;
        end
        @(posedge clk);
        #1 chk({d, bitAddrOk, timerCount, stackPtr, workRegister, signedRangeBit,
            halfCarryBit, carryFlag, zeroFlag}, {1'b1, a <= BIT_ADDR_MAX, et, esp, ew, ef});
        chk({i_mad_env.mem[wa + 8'h01], i_mad_env.mem[wa], i_mad_env.io[a]},
            {sm[wa + 8'h01], sm[wa], sio[a]});
    endtask
    initial begin
        #1000000 errors++;
        wrap_up();
    end
    initial begin
        for (int k = 0; k < 256; k++) begin
            {sm[k], sio[k]} = {8'(k * 7), ~8'(k)};
            {i_mad_env.mem[k], i_mad_env.io[k]} = {sm[k], sio[k]};
        end
        i_mad_env.timerCount = et;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        go(OP_MOV_A_I, 8'h80, 8'h00);
        go(OP_ADD_A_I, 8'h80, 8'h00);
        go(OP_MOV_M_A, 8'h00, 8'h3F);
        go(OP_MOV_A_M, 8'h00, 8'h40);
        go(OP_MOV_A_IO, 8'h00, 8'hFF);
        go(OP_MOV_IO_A, 8'h00, 8'h12);
        go(OP_XCH, 8'h00, 8'h21);
        go(OP_CLEAR_M, 8'h00, 8'h21);
        go(OP_IND_STORE, 8'h00, 8'h05);
        go(OP_IND_LOAD, 8'h00, 8'h05);
        $display("moves finished");
        for (int k = OP_ADD_A_I; k <= OP_DEC_M; k++) begin
            go(OP_MOV_A_I, 8'(k * 37), 8'h00);
            go(mad_op_e'(k), 8'h7F, 8'(8'h30 + k));
        end
        go(OP_MOV_A_I, 8'hFF, 8'h00);
        go(OP_MOV_M_A, 8'h00, 8'h3E);
        go(OP_INC_M, 8'h00, 8'h3E);
        $display("arithmetic finished");
        @(posedge clk);
        {stackLoad, stackLoadValue, esp} <= {1'b1, 8'h50, 8'h50};
        @(posedge clk);
        stackLoad <= 1'b0;
        go(OP_PUSH_FLAGS, 8'h00, 8'h00);
        go(OP_ADD_A_I, 8'h01, 8'h00);
        go(OP_POP_FLAGS, 8'h00, 8'h00);
        go(OP_TIMER_SNAP, 8'h00, 8'h60);
        go(OP_TIMER_PRESET, 8'h00, 8'h44);
        $display("stack and timer finished");
        wrap_up();
    end
endmodule
`default_nettype wire
